// >>> src/calu_pkg.sv
// Constants, field layouts and carrier types of the instruction-subset datapath
// Notes on behaviour
// - Subtract with borrow: file minus working minus inverted carry; update C, DC, Z.
// - Subtract with borrow: destination 0 writes working register, 1 the file register.
// - Nibble swap exchanges file bits 3:0 and 7:4; no flag changes.
// - Nibble swap: destination clear selects working register, set selects file register.
// - Literal XOR: working XOR 8-bit literal into working register; only Z changes.
// - Direction load copies working register to port A, B, C for 5, 6, 7.
// - File XOR: working XOR file; only Z changes; destination bit routes the result.
// - File operand is a 7-bit address 0 to 127 plus one destination bit.
package calu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam int unsigned CALU_ADDR_W = 12;
  localparam logic [11:0] CALU_OFS_INSTR = 12'h000;
  localparam logic [11:0] CALU_OFS_WORK = 12'h004;
  localparam logic [11:0] CALU_OFS_STATUS = 12'h008;
  localparam logic [11:0] CALU_OFS_DIR_A = 12'h00c;
  localparam logic [11:0] CALU_OFS_DIR_B = 12'h010;
  localparam logic [11:0] CALU_OFS_DIR_C = 12'h014;
  localparam logic [11:0] CALU_OFS_RESULT = 12'h018;
  localparam logic [11:0] CALU_OFS_FILE = 12'h200;
  localparam logic [2:0] CALU_FILE_SEL = 3'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CALU_RST_WORK = 8'h00;
  localparam logic [7:0] CALU_RST_DIR = 8'hff;
  localparam logic [7:0] CALU_RST_FILE = 8'h00;

  // Direction-load operands
  localparam logic [6:0] CALU_DIR_SEL_A = 7'h05;
  localparam logic [6:0] CALU_DIR_SEL_B = 7'h06;
  localparam logic [6:0] CALU_DIR_SEL_C = 7'h07;

  // Bus responses
  localparam logic [1:0] CALU_RESP_OKAY = 2'h0;
  localparam logic [1:0] CALU_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CALU_OP_NONE = 3'h0,
    CALU_OP_SUB = 3'h1,
    CALU_OP_SWAP = 3'h2,
    CALU_OP_XORL = 3'h3,
    CALU_OP_XORF = 3'h4,
    CALU_OP_DIR = 3'h5
  } calu_op_t;

  // Instruction word as written to the instruction register
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] literal;
    logic dest;
    logic [6:0] faddr;
    logic [4:0] rsvd_lo;
    logic [2:0] op;
  } calu_instr_t;

  // Status register layout, bits 7:4 read as zero
  typedef struct packed {
    logic [3:0] rsvd;
    logic rejected;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } calu_status_t;

endpackage

// >>> src/calu_core.sv
// Five-instruction execution datapath with working, file and direction registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module calu_core (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [calu_pkg::CALU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // Write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [calu_pkg::CALU_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // Read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Direction registers towards the port pins
  output logic [7:0] port_a_direction_reg,
  output logic [7:0] port_b_direction_reg,
  output logic [7:0] port_c_direction_reg
);
  import calu_pkg::*;
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Zero test shared by every result that updates the zero flag
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction
  // Whether a byte address falls inside the file register window
  function automatic logic file_hit(input logic [11:0] a);
    file_hit = (a[11:9] == CALU_FILE_SEL);
  endfunction
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] file_mem [0:127];
  logic [7:0] work_q, result_q, dir_a_q, dir_b_q, dir_c_q;
  calu_status_t status_q;
  logic aw_have_q, w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // ----------------------------------------------------------------
  // Write channel acceptance
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  // A write runs once address and data are both held and no response is pending
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire aw_have_d = (aw_have_q & ~wr_fire) | aw_take;
  wire w_have_d = (w_have_q & ~wr_fire) | w_take;
  // Address and data are taken in either order and parked until the write runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d;
      wready_q <= ~w_have_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end
  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire [11:0] wa = {awaddr_q[11:2], 2'b00};
  wire wr_instr = wr_fire & (wa == CALU_OFS_INSTR);
  wire wr_work = wr_fire & (wa == CALU_OFS_WORK);
  wire wr_status = wr_fire & (wa == CALU_OFS_STATUS);
  wire wr_dir_a = wr_fire & (wa == CALU_OFS_DIR_A);
  wire wr_dir_b = wr_fire & (wa == CALU_OFS_DIR_B);
  wire wr_dir_c = wr_fire & (wa == CALU_OFS_DIR_C);
  wire wr_result = wr_fire & (wa == CALU_OFS_RESULT);
  wire wr_file = wr_fire & file_hit(wa);
  wire wr_mapped = wr_instr | wr_work | wr_status | wr_dir_a | wr_dir_b | wr_dir_c
                   | wr_result | wr_file;
  wire [31:0] wword = wdata_q; // Lanes are qualified where each register takes them
  wire wlow = wstrb_q[0];
  // ----------------------------------------------------------------
  // Instruction operands and results
  // ----------------------------------------------------------------
  calu_instr_t ins;
  assign ins = calu_instr_t'(wword);
  // Instruction fields only count when every lane of the word was written
  wire ins_go = wr_instr & (wstrb_q == 4'hf);
  wire [6:0] fa = ins.faddr;
  wire [7:0] fval = file_mem[fa];
  // Subtract with borrow as f + ~W + C; the carry out is the inverted borrow
  wire [8:0] sub_full = {1'b0, fval} + {1'b0, ~work_q} + {8'h00, status_q.carry};
  wire [4:0] sub_low = {1'b0, fval[3:0]} + {1'b0, ~work_q[3:0]} + {4'h0, status_q.carry};
  wire [7:0] swap_res = {fval[3:0], fval[7:4]};
  wire [7:0] xorl_res = work_q ^ ins.literal;
  wire [7:0] xorf_res = work_q ^ fval;
  wire dir_sel_a = ins_go & (ins.op == CALU_OP_DIR) & (fa == CALU_DIR_SEL_A);
  wire dir_sel_b = ins_go & (ins.op == CALU_OP_DIR) & (fa == CALU_DIR_SEL_B);
  wire dir_sel_c = ins_go & (ins.op == CALU_OP_DIR) & (fa == CALU_DIR_SEL_C);
  wire dir_bad = (ins.op == CALU_OP_DIR) & ~(dir_sel_a | dir_sel_b | dir_sel_c);
  wire op_known = (ins.op <= CALU_OP_DIR);
  // Selected result, flag updates and destination for the current instruction
  logic [7:0] alu_res;
  logic alu_has_res, alu_to_file, upd_c, upd_z;
  always_comb begin
    alu_res = 8'h00;
    alu_has_res = 1'b0;
    alu_to_file = 1'b0;
    upd_c = 1'b0;
    upd_z = 1'b0;
    unique case (ins.op)
      CALU_OP_SUB: begin
        alu_res = sub_full[7:0];
        alu_has_res = 1'b1;
        alu_to_file = ins.dest;
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      CALU_OP_SWAP: begin
        alu_res = swap_res;
        alu_has_res = 1'b1;
        alu_to_file = ins.dest;
      end
      CALU_OP_XORL: begin
        alu_res = xorl_res;
        alu_has_res = 1'b1;
        upd_z = 1'b1;
      end
      CALU_OP_XORF: begin
        alu_res = xorf_res;
        alu_has_res = 1'b1;
        alu_to_file = ins.dest;
        upd_z = 1'b1;
      end
      default: begin
        // No operation, direction load and unused codes leave carry, digit carry and zero alone
        alu_has_res = 1'b0;
      end
    endcase
  end
  wire res_go = ins_go & alu_has_res;
  wire res_to_work = res_go & ~alu_to_file;
  wire res_to_file = res_go & alu_to_file;
  wire reject_set = ins_go & (dir_bad | ~op_known);
  // ----------------------------------------------------------------
  // Working register, flags and last result
  // ----------------------------------------------------------------
  // Working register: software write or instruction writeback, never both in one write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_q <= CALU_RST_WORK;
    end else if (res_to_work) begin
      work_q <= alu_res;
    end else if (wr_work && wlow) begin
      work_q <= wword[7:0];
    end
  end
  // Flags; the reject flag is sticky and a new reject wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else begin
      if (wr_status && wlow) begin
        status_q.carry <= wword[0];
        status_q.digit_carry_flag <= wword[1];
        status_q.zero <= wword[2];
        status_q.rejected <= wword[3];
      end
      if (res_go && upd_c) begin
        status_q.carry <= sub_full[8];
        status_q.digit_carry_flag <= sub_low[4];
      end
      if (res_go && upd_z) begin
        status_q.zero <= is_zero(alu_res);
      end
      if (reject_set) begin
        status_q.rejected <= 1'b1;
      end
    end
  end
  // Last result kept for software, including results written to a file register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 8'h00;
    end else if (res_go) begin
      result_q <= alu_res;
    end
  end
  // ----------------------------------------------------------------
  // Direction registers
  // ----------------------------------------------------------------
  // All pins start as inputs; a direction load copies the working register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_a_q <= CALU_RST_DIR;
      dir_b_q <= CALU_RST_DIR;
      dir_c_q <= CALU_RST_DIR;
    end else begin
      if (dir_sel_a) begin
        dir_a_q <= work_q;
      end else if (wr_dir_a && wlow) begin
        dir_a_q <= wword[7:0];
      end
      if (dir_sel_b) begin
        dir_b_q <= work_q;
      end else if (wr_dir_b && wlow) begin
        dir_b_q <= wword[7:0];
      end
      if (dir_sel_c) begin
        dir_c_q <= work_q;
      end else if (wr_dir_c && wlow) begin
        dir_c_q <= wword[7:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // File registers
  // ----------------------------------------------------------------
  wire [6:0] sw_fa = wa[8:2];
  wire file_we = res_to_file | (wr_file & wlow);
  wire [6:0] file_wa = res_to_file ? fa : sw_fa;
  wire [7:0] file_wd = res_to_file ? alu_res : wword[7:0];
  // The array is cleared in reset so reads never return an undefined byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 128; i++) begin
        file_mem[i] <= CALU_RST_FILE;
      end
    end else if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end
  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  // Response follows the executed write by one edge; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= CALU_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? CALU_RESP_OKAY : CALU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid & arready_q;
  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  // Read multiplexer; bits above a register's width read as zero
  logic [31:0] rmux;
  logic rhit;
  always_comb begin
    rhit = 1'b1;
    rmux = 32'h0000_0000;
    if (file_hit(ra)) begin
      rmux = {24'h000000, file_mem[ra[8:2]]};
    end else if (ra == CALU_OFS_INSTR) begin
      rmux = 32'h0000_0000; // Instruction register is write-only
    end else if (ra == CALU_OFS_WORK) begin
      rmux = {24'h000000, work_q};
    end else if (ra == CALU_OFS_STATUS) begin
      rmux = {24'h000000, status_q};
    end else if (ra == CALU_OFS_DIR_A) begin
      rmux = {24'h000000, dir_a_q};
    end else if (ra == CALU_OFS_DIR_B) begin
      rmux = {24'h000000, dir_b_q};
    end else if (ra == CALU_OFS_DIR_C) begin
      rmux = {24'h000000, dir_c_q};
    end else if (ra == CALU_OFS_RESULT) begin
      rmux = {24'h000000, result_q};
    end else begin
      rhit = 1'b0;
    end
  end
  // One read outstanding: the address channel closes until the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= CALU_RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rmux;
      rresp_q <= rhit ? CALU_RESP_OKAY : CALU_RESP_SLVERR;
    end else if (!rvalid_q || s_axi_rready) begin
      rvalid_q <= 1'b0; // A taken answer, or none pending, reopens the address channel
      arready_q <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign port_a_direction_reg = dir_a_q;
  assign port_b_direction_reg = dir_b_q;
  assign port_c_direction_reg = dir_c_q;
endmodule

// >>> test/calu_chk.sv
// Concurrent checks on the bus handshakes and direction outputs of the datapath
`timescale 1ns/100ps
module calu_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Direction outputs
  input wire logic [7:0] port_a_direction_reg,
  input wire logic [7:0] port_b_direction_reg,
  input wire logic [7:0] port_c_direction_reg
);
  import calu_pkg::*;
  // ----------------------------------------------------------------
  // Handshake steps
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data met in one cycle
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Any direction output moved since the last edge
  sequence s_dir_moved;
    $changed(port_a_direction_reg) || $changed(port_b_direction_reg) ||
      $changed(port_c_direction_reg);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_write_answer_time: assert property (s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two edges after take");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_bvalid_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer_time: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read data not one edge after take");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed while waiting");
  a_rvalid_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_read_gate_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while read pending");
  a_unmapped_read: assert property ((s_read_taken and (s_axi_araddr >= 12'h01c &&
    s_axi_araddr < 12'h200)) |=> s_axi_rresp == CALU_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_dir_reset_val: assert property ($rose(aresetn) |-> port_a_direction_reg == 8'hff &&
    port_b_direction_reg == 8'hff && port_c_direction_reg == 8'hff)
    else $error("direction outputs not at reset value");
  a_dir_by_write: assert property (s_dir_moved |-> ##[0:1] s_axi_bvalid)
    else $error("direction output moved without a write");
endmodule
bind calu_core calu_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .port_a_direction_reg, .port_b_direction_reg,
  .port_c_direction_reg);

// >>> test/calu_bench.sv
// Self-checking bench: random instructions through the register bus, checked by a model
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module calu_bench;
  import calu_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rv;
  logic [7:0] port_a_direction_reg, port_b_direction_reg, port_c_direction_reg;
  logic [7:0] w, fv, lit, ew, ef, er;
  logic [2:0][7:0] edir;
  logic [6:0] fa;
  logic [2:0] op, st;
  logic [3:0] est;
  logic [11:0] fadr;
  logic d;
  int n_errors = 0, checked = 0, cycles = 0, i;

  always #5 aclk = ~aclk;

  // Byte lanes and protection stay fixed: every register takes a full word
  calu_core dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .port_a_direction_reg, .port_b_direction_reg, .port_c_direction_reg);

  // ----------------------------------------------------------------
  // Bus master tasks, response ready raised after a random stall
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int k;
    k = $urandom_range(3, 0);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (k == 0) s_axi_bready <= 1'b1;
      else k--;
    end
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    int k;
    k = $urandom_range(3, 0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (k == 0) s_axi_rready <= 1'b1;
      else k--;
    end
    v = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // Expected destination values and flags of one instruction
  function automatic void predict();
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    s = {1'b0, fv} + {1'b0, ~w} + 9'(est[0]);
    h = {1'b0, fv[3:0]} + {1'b0, ~w[3:0]} + 5'(est[0]);
    case (op)
      3'h1: begin
        r = s[7:0];
        est[1:0] = {h[4], s[8]};
      end
      3'h2: r = {fv[3:0], fv[7:4]};
      3'h3: r = w ^ lit;
      3'h4: r = w ^ fv;
      default: r = 8'h00;
    endcase
    if (op != 3'h5) er = r;
    if (op == 3'h1 || op == 3'h3 || op == 3'h4) est[2] = (r == 8'h00);
    if (op == 3'h5) edir[fa[1:0] - 2'h1] = w;
    else if (op == 3'h3 || !d) ew = r;
    else ef = r;
  endfunction

  task automatic wrap_up;
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, far above the fewer than two thousand cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hed54a49d));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    edir = {3{8'hff}};
    er = 8'h00;
    for (i = 0; i < 40; i++) begin
      w = 8'($urandom);
      fv = 8'($urandom);
      lit = 8'($urandom);
      d = 1'($urandom);
      fa = 7'($urandom);
      st = 3'($urandom);
      op = 3'($urandom_range(5, 1));
      if (op == 3'h5) fa = 7'($urandom_range(7, 5));
      // Corners: zero difference, top address, borrow out of the bottom address
      if (i == 0) begin
        op = 3'h1;
        fv = w;
        st = 3'h1;
      end
      if (i == 1) begin
        op = 3'h4;
        fv = w;
        fa = 7'h7f;
      end
      if (i == 2) begin
        op = 3'h1;
        fa = 7'h00;
        fv = 8'h00;
        w = 8'h01;
      end
      fadr = CALU_OFS_FILE + {3'h0, fa, 2'h0};
      wr(CALU_OFS_WORK, {24'h0, w});
      wr(fadr, {24'h0, fv});
      wr(CALU_OFS_STATUS, {29'h0, st});
      wr(CALU_OFS_INSTR, {8'h0, lit, d, fa, 5'h0, op});
      ew = w;
      ef = fv;
      est = {1'b0, st};
      predict();
      rd(CALU_OFS_WORK, rv);
      `CHK(rv, {24'h0, ew})
      rd(fadr, rv);
      `CHK(rv, {24'h0, ef})
      rd(CALU_OFS_STATUS, rv);
      `CHK(rv, {28'h0, est})
      rd(CALU_OFS_RESULT, rv);
      `CHK(rv, {24'h0, er})
      `CHK({port_c_direction_reg, port_b_direction_reg, port_a_direction_reg}, edir)
    end
    // Direction load outside 5..7 is refused and leaves the port C direction register alone
    wr(CALU_OFS_STATUS, 32'h0);
    wr(CALU_OFS_INSTR, {16'h0, 8'h04, 5'h0, 3'h5});
    rd(CALU_OFS_STATUS, rv);
    `CHK(rv, 32'h8)
    rd(CALU_OFS_DIR_C, rv);
    `CHK(rv[7:0], edir[2])
    // The empty operation changes no flag; an unused code is refused
    wr(CALU_OFS_STATUS, 32'h0);
    wr(CALU_OFS_INSTR, 32'h0000_0000);
    rd(CALU_OFS_STATUS, rv);
    `CHK(rv, 32'h0)
    wr(CALU_OFS_INSTR, {29'h0, 3'h7});
    rd(CALU_OFS_STATUS, rv);
    `CHK(rv, 32'h8)
    // Unmapped place refuses both directions
    wr(12'h100, 32'h5a);
    `CHK(resp, CALU_RESP_SLVERR)
    rd(12'h100, rv);
    `CHK({resp, rv}, {CALU_RESP_SLVERR, 32'h0})
    wrap_up;
  end
endmodule
